//--- hw/vatu_tbuf.sv
// translation buffer: fully associative, round-robin replacement
// assumes entries are loaded only through the lookup interface
`timescale 1ns/1ps
`default_nettype none
module vatu_tbuf #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // lookup port
    vatu_lookup_if.buffer lk
);
    import vatu_pkg::*;
    localparam int IW = $clog2(N);
    vatu_entry_t ent_r [N]; // entry storage
    logic [IW-1:0] rep_r; // replacement pointer
    logic [N-1:0] match; // per-entry hit
    logic [VATU_PA_W-1:0] pa_sel; // selected address

    // ---------------------------------------------------------------
    // compare
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            // single mode ignores the tag for matching
            assign match[g] = ent_r[g].valid
                && ent_r[g].virtual_page_field == lk.va[31:VATU_VPN_LSB]
                && (lk.single_mode || ent_r[g].tag == lk.tag);
        end
    endgenerate

    // select the matching entry's address
    always_comb begin
        pa_sel = '0;
        for (int i = 0; i < N; i++) begin
            if (match[i]) begin
                pa_sel = ent_r[i].pa;
            end
        end
    end
    assign lk.hit = |match;
    assign lk.pa = pa_sel;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    // load the next entry, clear all on reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < N; i++) begin
                ent_r[i] <= '0;
            end
            rep_r <= '0;
        end else if (lk.wr_en) begin
            ent_r[rep_r] <= lk.wr_entry;
            rep_r <= IW'((int'(rep_r) + 1) % N);
        end
    end
endmodule
`default_nettype wire

//--- hw/vatu_top.sv
// virtual address translation unit: region decode, buffers, registers
// assumes the core holds a request stable until it is answered
`timescale 1ns/1ps
`default_nettype none
module vatu_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // instruction fetch path
    input wire logic ifetch_req,
    input wire logic [31:0] ifetch_va,
    output logic ifetch_ack,
    output logic [31:0] ifetch_pa,
    output logic ifetch_miss,
    // data access path
    input wire logic data_req,
    input wire logic [31:0] data_va,
    input wire logic data_translated,
    output logic data_ack,
    output logic [31:0] data_pa,
    output logic data_miss,
    output logic data_is_reg,
    // register access, within a data access
    input wire logic reg_we,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // core events
    input wire logic addr_err,
    input wire logic [31:0] addr_err_va,
    input wire logic load_entry_op,
    // exception and refetch control
    output logic miss_exc,
    output logic [31:0] miss_epc_va,
    output logic refetch_next,
    // register views
    output logic [31:0] table_base,
    output logic [31:0] space_control
);
    import vatu_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [31:0] peh_r, peh_nxt; // page entry high
    logic [31:0] pel_r; // page entry low
    logic [31:0] ttb_r; // table base
    logic [31:0] fac_r, fac_nxt; // fault address
    logic [31:0] ctl_r; // translation control
    logic [31:0] psc_r; // physical space control
    logic [31:0] ric_r; // refetch inhibit
    // output flops
    logic ifetch_ack_r, ifetch_miss_r, data_ack_r, data_miss_r, data_is_reg_r;
    logic [31:0] ifetch_pa_r, data_pa_r, reg_rdata_r;
    logic miss_exc_r, refetch_r;
    logic [31:0] epc_r;

    // access phase
    typedef enum logic [1:0] {VATU_IDLE, VATU_DONE} vatu_state_t;
    vatu_state_t ist_r, dst_r;

    // ---------------------------------------------------------------
    // region decode
    // ---------------------------------------------------------------
    // classify by top address bits
    function automatic vatu_region_t region_of(input logic [31:0] va);
        if (!va[31]) begin
            region_of = VATU_RG_LOW;
        end else begin
            case (va[31:29])
                3'h4: region_of = VATU_RG_CDIR;
                3'h5: region_of = VATU_RG_UDIR;
                3'h6: region_of = VATU_RG_PRIV;
                default: region_of = VATU_RG_CTRL;
            endcase
        end
    endfunction

    // direct physical address, top three bits forced to zero
    function automatic logic [31:0] direct_pa(input logic [31:0] va);
        direct_pa = {3'h0, va[28:0]};
    endfunction

    // true for a register address in either view
    function automatic logic is_reg_addr(input logic [31:0] a);
        logic [31:0] base;
        base = a & ~VATU_REG_MASK;
        is_reg_addr = (base == VATU_CTRL_BASE) || (base == VATU_MIRROR_BASE);
    endfunction

    vatu_region_t i_rg, d_rg;
    assign i_rg = region_of(ifetch_va);
    assign d_rg = region_of(data_va);

    wire logic xlate_on = ctl_r[VATU_CTL_AT_BIT];
    wire logic single_mode = ctl_r[VATU_CTL_SV_BIT];
    wire logic [VATU_TAG_W-1:0] cur_tag = peh_r[VATU_TAG_W-1:0];

    // ---------------------------------------------------------------
    // buffers
    // ---------------------------------------------------------------
    vatu_lookup_if ilk();
    vatu_lookup_if ulk();

    vatu_tbuf #(.N(VATU_ITB_N)) u_itb (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lk(ilk.buffer)
    );
    vatu_tbuf #(.N(VATU_UTB_N)) u_utb (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lk(ulk.buffer)
    );

    // fetch searches the instruction buffer, data the unified one
    assign ilk.va = ifetch_va;
    assign ulk.va = data_va;
    assign ilk.tag = cur_tag;
    assign ulk.tag = cur_tag;
    assign ilk.single_mode = single_mode;
    assign ulk.single_mode = single_mode;

    // load op copies page field and tag with low register payload
    vatu_entry_t new_ent;
    assign new_ent.valid = pel_r[8];
    assign new_ent.virtual_page_field = peh_r[31:VATU_VPN_LSB];
    assign new_ent.tag = peh_r[VATU_TAG_W-1:0];
    assign new_ent.pa = {pel_r[28:10], 10'h000};
    assign ulk.wr_en = load_entry_op;
    assign ulk.wr_entry = new_ent;
    // instruction buffer takes the same load
    assign ilk.wr_en = load_entry_op;
    assign ilk.wr_entry = new_ent;

    // ---------------------------------------------------------------
    // translation results
    // ---------------------------------------------------------------
    // an address needs the buffer only in translated regions with
    // translation enabled
    wire logic i_needs = xlate_on && (i_rg == VATU_RG_LOW || i_rg == VATU_RG_PRIV);
    wire logic d_needs = xlate_on && (d_rg == VATU_RG_LOW || d_rg == VATU_RG_PRIV);
    wire logic i_bypass = (i_rg == VATU_RG_CTRL);
    wire logic d_bypass = (d_rg == VATU_RG_CTRL);
    // page from the entry, offset kept from the address
    wire logic [31:0] i_xl_pa = {3'h0, ilk.pa[28:10], ifetch_va[9:0]};
    wire logic [31:0] d_xl_pa = {3'h0, ulk.pa[28:10], data_va[9:0]};

    // fetch address selection
    wire logic [31:0] i_pa_w = i_bypass ? ifetch_va :
        i_needs ? i_xl_pa : direct_pa(ifetch_va);
    wire logic i_miss_w = i_needs && !ilk.hit;
    // data address selection
    wire logic [31:0] d_pa_w = d_bypass ? data_va :
        d_needs ? d_xl_pa : direct_pa(data_va);
    wire logic d_miss_w = d_needs && !ulk.hit;

    // register hit: control view direct, mirror only when translated
    wire logic [31:0] d_reg_addr = d_needs ? d_xl_pa : data_va;
    wire logic d_reg_hit = !d_miss_w && (d_bypass || (d_needs && data_translated))
        && is_reg_addr(d_reg_addr);
    wire logic [7:0] d_reg_off = d_reg_addr[7:0];
    wire logic reg_wr = data_req && dst_r == VATU_IDLE && d_reg_hit && reg_we;
    wire logic is_peh_wr = reg_wr && d_reg_off == VATU_OFS_PEH[7:0];

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (d_reg_off)
            VATU_OFS_PEH[7:0]: rd_mux = peh_r & VATU_PEH_MASK;
            VATU_OFS_PEL[7:0]: rd_mux = pel_r;
            VATU_OFS_TTB[7:0]: rd_mux = ttb_r;
            VATU_OFS_FAC[7:0]: rd_mux = fac_r;
            VATU_OFS_CTL[7:0]: rd_mux = ctl_r;
            VATU_OFS_PSC[7:0]: rd_mux = psc_r;
            VATU_OFS_RIC[7:0]: rd_mux = ric_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // fault capture: any miss or address error writes page field
    wire logic i_fault = ifetch_req && ist_r == VATU_IDLE && i_miss_w;
    wire logic d_fault = data_req && dst_r == VATU_IDLE && d_miss_w;
    wire logic [31:0] fault_va = d_fault ? data_va : i_fault ? ifetch_va : addr_err_va;
    wire logic any_fault = i_fault || d_fault || addr_err;

    // page entry high next value: tag only from software
    always_comb begin
        peh_nxt = peh_r;
        if (is_peh_wr) begin
            peh_nxt = reg_wdata & VATU_PEH_MASK;
        end
        if (any_fault) begin
            peh_nxt[31:VATU_VPN_LSB] = fault_va[31:VATU_VPN_LSB];
        end
    end
    always_comb begin
        fac_nxt = fac_r;
        if (reg_wr && d_reg_off == VATU_OFS_FAC[7:0]) begin
            fac_nxt = reg_wdata;
        end
        if (any_fault) begin
            fac_nxt = fault_va;
        end
    end

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    // control registers cleared by reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_r <= VATU_CTL_RST;
            psc_r <= VATU_PSC_RST;
            ric_r <= VATU_RIC_RST;
        end else if (reg_wr) begin
            if (d_reg_off == VATU_OFS_CTL[7:0]) ctl_r <= reg_wdata;
            if (d_reg_off == VATU_OFS_PSC[7:0]) psc_r <= reg_wdata;
            if (d_reg_off == VATU_OFS_RIC[7:0]) ric_r <= reg_wdata;
        end
    end

    // undefined-at-reset registers are just held
    always_ff @(posedge ref_clk) begin
        peh_r <= peh_nxt;
        fac_r <= fac_nxt;
        if (reg_wr && d_reg_off == VATU_OFS_PEL[7:0]) pel_r <= reg_wdata;
        if (reg_wr && d_reg_off == VATU_OFS_TTB[7:0]) ttb_r <= reg_wdata;
    end

    // ---------------------------------------------------------------
    // access handshake
    // ---------------------------------------------------------------
    // fetch: answer one cycle after request, then wait for drop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ist_r <= VATU_IDLE;
            ifetch_ack_r <= 1'b0;
            ifetch_miss_r <= 1'b0;
            ifetch_pa_r <= 32'h0000_0000;
        end else begin
            case (ist_r)
                VATU_IDLE: begin
                    ifetch_ack_r <= ifetch_req && !i_miss_w;
                    ifetch_miss_r <= i_fault;
                    ifetch_pa_r <= i_miss_w ? 32'h0000_0000 : i_pa_w;
                    if (ifetch_req) ist_r <= VATU_DONE;
                end
                VATU_DONE: begin
                    ifetch_ack_r <= 1'b0;
                    ifetch_miss_r <= 1'b0;
                    if (!ifetch_req) ist_r <= VATU_IDLE;
                end
                default: ist_r <= VATU_IDLE;
            endcase
        end
    end

    // data: same handshake, plus register read data
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dst_r <= VATU_IDLE;
            data_ack_r <= 1'b0;
            data_miss_r <= 1'b0;
            data_is_reg_r <= 1'b0;
            data_pa_r <= 32'h0000_0000;
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            case (dst_r)
                VATU_IDLE: begin
                    data_ack_r <= data_req && !d_miss_w;
                    data_miss_r <= d_fault;
                    data_is_reg_r <= data_req && d_reg_hit;
                    data_pa_r <= d_miss_w ? 32'h0000_0000 : d_pa_w;
                    reg_rdata_r <= (data_req && d_reg_hit) ? rd_mux : 32'h0000_0000;
                    if (data_req) dst_r <= VATU_DONE;
                end
                VATU_DONE: begin
                    data_ack_r <= 1'b0;
                    data_miss_r <= 1'b0;
                    data_is_reg_r <= 1'b0;
                    if (!data_req) dst_r <= VATU_IDLE;
                end
                default: dst_r <= VATU_IDLE;
            endcase
        end
    end

    // exception: report the faulting address so the core restarts
    // that very instruction after the handler
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            miss_exc_r <= 1'b0;
            epc_r <= 32'h0000_0000;
            refetch_r <= 1'b0;
        end else begin
            miss_exc_r <= i_fault || d_fault;
            if (i_fault || d_fault) epc_r <= fault_va;
            // tag update with suppress bit clear forces a refetch
            refetch_r <= is_peh_wr && !ric_r[VATU_RIC_R2_BIT]
                && reg_wdata[7:0] != peh_r[7:0];
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign ifetch_ack = ifetch_ack_r;
    assign ifetch_pa = ifetch_pa_r;
    assign ifetch_miss = ifetch_miss_r;
    assign data_ack = data_ack_r;
    assign data_pa = data_pa_r;
    assign data_miss = data_miss_r;
    assign data_is_reg = data_is_reg_r;
    assign reg_rdata = reg_rdata_r;
    assign miss_exc = miss_exc_r;
    assign miss_epc_va = epc_r;
    assign refetch_next = refetch_r;
    assign table_base = ttb_r;
    assign space_control = psc_r;
endmodule
`default_nettype wire

//--- shared/vatu_lookup_if.sv
// lookup request and result between the top and a translation buffer
// assumes one shared clock; results are combinational
`timescale 1ns/1ps
`default_nettype none
interface vatu_lookup_if;
    import vatu_pkg::*;
    logic [31:0] va; // virtual address searched
    logic [VATU_TAG_W-1:0] tag; // current process tag
    logic single_mode; // single space compare
    logic hit; // an entry matched
    logic [VATU_PA_W-1:0] pa; // translated address
    logic wr_en; // load an entry
    vatu_entry_t wr_entry; // entry loaded
    modport owner(output va, tag, single_mode, wr_en, wr_entry, input hit, pa);
    modport buffer(input va, tag, single_mode, wr_en, wr_entry, output hit, pa);
endinterface
`default_nettype wire

//--- shared/vatu_pkg.sv
// package for the virtual address translation unit
// assumes a 32-bit core address path and a single core clock
package vatu_pkg;
    // register offsets, control-region view
    localparam logic [31:0] VATU_OFS_PEH = 32'hff00_0000;
    localparam logic [31:0] VATU_OFS_PEL = 32'hff00_0004;
    localparam logic [31:0] VATU_OFS_TTB = 32'hff00_0008;
    localparam logic [31:0] VATU_OFS_FAC = 32'hff00_000c;
    localparam logic [31:0] VATU_OFS_CTL = 32'hff00_0010;
    localparam logic [31:0] VATU_OFS_PSC = 32'hff00_0070;
    localparam logic [31:0] VATU_OFS_RIC = 32'hff00_0078;
    // mirror base in physical area 7
    localparam logic [31:0] VATU_MIRROR_BASE = 32'h1f00_0000;
    localparam logic [31:0] VATU_CTRL_BASE = 32'hff00_0000;
    localparam logic [31:0] VATU_REG_MASK = 32'h0000_00ff;
    // page entry high fields
    localparam int VATU_VPN_LSB = 10;
    localparam int VATU_VPN_W = 22;
    localparam int VATU_TAG_LSB = 0;
    localparam int VATU_TAG_W = 8;
    localparam logic [31:0] VATU_PEH_MASK = 32'hffff_fcff;
    // control fields
    localparam int VATU_CTL_AT_BIT = 0;
    localparam int VATU_CTL_SV_BIT = 8;
    localparam int VATU_RIC_R2_BIT = 4;
    // reset values
    localparam logic [31:0] VATU_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] VATU_PSC_RST = 32'h0000_0000;
    localparam logic [31:0] VATU_RIC_RST = 32'h0000_0000;
    // buffer sizes and physical width
    localparam int VATU_ITB_N = 4;
    localparam int VATU_UTB_N = 16;
    localparam int VATU_PA_W = 29;
    // region decode
    typedef enum logic [2:0] {
        VATU_RG_LOW, VATU_RG_CDIR, VATU_RG_UDIR, VATU_RG_PRIV, VATU_RG_CTRL
    } vatu_region_t;
    // one translation entry
    typedef struct packed {
        logic valid;
        logic [VATU_VPN_W-1:0] virtual_page_field;
        logic [VATU_TAG_W-1:0] tag;
        logic [VATU_PA_W-1:0] pa;
    } vatu_entry_t;
endpackage

//--- tb/vatu_fetch_model.sv
// fetch unit model: one fetch per go
// assumes an answer one cycle after a take
`timescale 1ns/1ps
`default_nettype none
module vatu_fetch_model (
    // clock
    input wire logic ref_clk,
    // command side
    input wire logic go,
    input wire logic [31:0] go_va,
    input wire logic [3:0] gap,
    output logic done,
    output logic missed,
    // unit side
    output logic ifetch_req,
    output logic [31:0] ifetch_va,
    input wire logic ifetch_ack,
    input wire logic ifetch_miss
);
    initial begin
        ifetch_req = 1'b0;
        ifetch_va = 32'h0000_0000;
        done = 1'b0;
        missed = 1'b0;
    end
    // hold request and address to the answer edge
    always @(posedge go) begin
        done = 1'b0;
        repeat (gap) @(negedge ref_clk);
        @(negedge ref_clk);
        ifetch_va = go_va;
        ifetch_req = 1'b1;
        for (int i = 0; i < 8 && ifetch_ack !== 1'b1 && ifetch_miss !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        missed = ifetch_miss;
        @(posedge ref_clk);
        @(negedge ref_clk);
        ifetch_req = 1'b0;
        // released lines show the inverse
        ifetch_va = ~go_va;
        done = 1'b1;
    end
endmodule
`default_nettype wire

//--- tb/vatu_props.sv
// checker: port timing and mapping of the translation unit
// assumes a bind to vatu_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module vatu_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // fetch path
    input wire logic ifetch_req,
    input wire logic [31:0] ifetch_va,
    input wire logic ifetch_ack,
    input wire logic [31:0] ifetch_pa,
    input wire logic ifetch_miss,
    // data path
    input wire logic data_req,
    input wire logic [31:0] data_va,
    input wire logic data_ack,
    input wire logic [31:0] data_pa,
    input wire logic data_miss,
    input wire logic data_is_reg,
    input wire logic reg_we,
    // events and register views
    input wire logic miss_exc,
    input wire logic [31:0] miss_epc_va,
    input wire logic refetch_next,
    input wire logic [31:0] space_control
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // access steps
    // ------------------------------------------------------------
    // a request is taken where it first shows
    sequence d_take;
        $rose(data_req);
    endsequence
    sequence f_take;
        $rose(ifetch_req);
    endsequence
    // taken data request aimed at a direct region
    sequence d_direct;
        d_take ##0 (data_va[31:30] == 2'h2);
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    data_answer_a: assert property (
        d_take |=> data_ack ^ data_miss) else $error("data access not answered");
    fetch_answer_a: assert property (
        f_take |=> ifetch_ack ^ ifetch_miss) else $error("fetch not answered");
    direct_map_a: assert property (
        d_direct |=> data_ack && data_pa == ($past(data_va) & 32'h1fff_ffff))
        else $error("direct data address wrong");
    fetch_direct_a: assert property (
        f_take ##0 (ifetch_va[31:30] == 2'h2)
        |=> ifetch_ack && ifetch_pa == ($past(ifetch_va) & 32'h1fff_ffff))
        else $error("direct fetch address wrong");
    ctrl_bypass_a: assert property (
        d_take ##0 (data_va[31:8] == 24'hff_0000) |=> data_ack && data_is_reg)
        else $error("control access not bypassed");
    miss_raise_a: assert property (
        (data_miss || ifetch_miss) |-> miss_exc) else $error("miss without exception");
    epc_hold_a: assert property (
        data_miss |-> miss_epc_va == data_va) else $error("re-execute point wrong");
    refetch_cause_a: assert property (
        refetch_next |-> $past(reg_we) || $past(reg_we, 2))
        else $error("refetch without a register write");
    reset_clear_a: assert property (
        $fell(sys_rst) |-> space_control == 32'h0000_0000)
        else $error("space control not cleared");
endmodule
`default_nettype wire

//--- tb/vatu_top_test.sv
// bench for the translation unit: registers, regions, misses, entries
// assumes an answer one cycle after a taken request
`timescale 1ns/1ps
`default_nettype none
module vatu_top_test;
    import vatu_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic data_req = 1'b0;
    logic [31:0] data_va = 32'h0000_0000;
    logic data_translated = 1'b0;
    logic reg_we = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic addr_err = 1'b0;
    logic [31:0] addr_err_va = 32'h0000_0000;
    logic load_entry_op = 1'b0;
    logic go = 1'b0;
    logic [31:0] go_va = 32'h0000_0000;
    logic [3:0] gap = 4'h0;
    logic done, missed, ifetch_req, ifetch_ack, ifetch_miss;
    logic data_ack, data_miss, data_is_reg, miss_exc, refetch_next;
    logic [31:0] ifetch_va, ifetch_pa, data_pa, reg_rdata, miss_epc_va;
    logic [31:0] table_base, space_control;
    // captured answers and expectations
    logic [31:0] pa_v, rd_v, translation_table_base, va, pel, peh;
    logic miss_v, isreg_v;
    logic [31:0] rz [3] = '{VATU_OFS_CTL, VATU_OFS_PSC, VATU_OFS_RIC};
    int failures = 0;
    int n_tests = 0;
    int n_ref = 0, n_exc = 0, k;
    always #10 ref_clk = ~ref_clk;
    vatu_top vatu_top_inst (.*);
    vatu_fetch_model vatu_fetch_model_inst (.*);
    // count event pulses
    always @(posedge ref_clk) begin
        if (refetch_next === 1'b1) n_ref++;
        if (miss_exc === 1'b1) n_exc++;
    end
    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] dir_pa(input logic [31:0] a);
        return a & 32'h1fff_ffff;
    endfunction
    function automatic logic [31:0] tl_pa(input logic [31:0] l, input logic [31:0] a);
        return {3'h0, l[28:10], a[9:0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp, input string what);
        cmp({31'h0, got}, {31'h0, exp}, what);
    endtask
    // one data access, held to the answer edge
    task automatic dacc(input logic [31:0] a, input logic we, input logic [31:0] wd,
        input logic tr);
        @(negedge ref_clk);
        data_va = a;
        reg_we = we;
        reg_wdata = wd;
        data_translated = tr;
        data_req = 1'b1;
        for (int i = 0; i < 8 && data_ack !== 1'b1 && data_miss !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        pa_v = data_pa;
        rd_v = reg_rdata;
        miss_v = data_miss;
        isreg_v = data_is_reg;
        @(posedge ref_clk);
        @(negedge ref_clk);
        data_req = 1'b0;
        reg_we = 1'b0;
        data_translated = 1'b0;
        data_va = ~a;
        reg_wdata = ~wd;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        dacc(a, 1'b1, d, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a);
        dacc(a, 1'b0, 32'h0000_0000, 1'b0);
    endtask
    // entries are loaded from page entry high as it stands
    task automatic ld(input logic [31:0] l);
        wr(VATU_OFS_PEL, l);
        @(negedge ref_clk);
        load_entry_op = 1'b1;
        @(negedge ref_clk);
        load_entry_op = 1'b0;
    endtask
    task automatic ftch(input logic [31:0] a);
        @(negedge ref_clk);
        go_va = a;
        gap = 4'($urandom_range(3));
        go = 1'b1;
        @(posedge done);
        go = 1'b0;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence of tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'he95b));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        // cleared registers, via the control region
        foreach (rz[i]) begin
            rd(rz[i]);
            cmp(rd_v, 32'h0000_0000, "reset value");
            cmpb(isreg_v, 1'b1, "control hit");
        end
        translation_table_base = $urandom();
        wr(VATU_OFS_TTB, translation_table_base);
        rd(VATU_OFS_TTB);
        cmp(rd_v, translation_table_base, "table base");
        cmp(table_base, translation_table_base, "table base out");
        // page entry high layout and refetch on a tag change
        peh = $urandom();
        wr(VATU_OFS_PEH, peh);
        k = n_ref;
        peh = peh ^ 32'h0000_0001;
        wr(VATU_OFS_PEH, peh);
        rd(VATU_OFS_PEH);
        cmp(rd_v, peh & VATU_PEH_MASK, "entry high");
        cmpb(n_ref > k, 1'b1, "refetch");
        wr(VATU_OFS_RIC, 32'h0000_0010);
        k = n_ref;
        peh = peh ^ 32'h0000_0002;
        wr(VATU_OFS_PEH, peh);
        rd(VATU_OFS_PEH);
        cmpb(n_ref == k, 1'b1, "suppressed refetch");
        wr(VATU_OFS_RIC, 32'h0000_0000);
        // direct regions, translation off then on
        for (int i = 0; i < 8; i++) begin
            if (i == 4) wr(VATU_OFS_CTL, 32'h0000_0001);
            va = {2'h2, 30'($urandom())};
            rd(va);
            cmp(pa_v, dir_pa(va), "direct data");
            cmpb(miss_v, 1'b0, "direct no miss");
            ftch(va);
            cmp(ifetch_pa, dir_pa(va), "direct fetch");
            if (i < 4) begin
                va[31] = 1'b0;
                rd(va);
                cmp(pa_v, dir_pa(va), "untranslated low");
            end
        end
        // translated miss captures the page, keeps the tag
        va = {1'h0, 31'($urandom())};
        k = n_exc;
        rd(va);
        cmpb(miss_v, 1'b1, "miss");
        rd(VATU_OFS_PEH);
        cmpb(n_exc > k, 1'b1, "miss exception");
        cmp(rd_v, {va[31:10], 2'h0, peh[7:0]}, "fault page");
        // load from the captured page, then the access runs again and hits
        pel = {3'h0, 19'($urandom()), 10'h100};
        ld(pel);
        rd(va);
        cmp(pa_v, tl_pa(pel, va), "data hit");
        ftch(va);
        cmp(ifetch_pa, tl_pa(pel, va), "fetch hit");
        cmpb(missed, 1'b0, "fetch no miss");
        // another tag misses in multiple mode and hits in single mode
        peh = {va[31:10], 2'h0, peh[7:0] ^ 8'h5a};
        wr(VATU_OFS_PEH, peh);
        rd(va);
        cmpb(miss_v, 1'b1, "tag mismatch");
        wr(VATU_OFS_CTL, 32'h0000_0101);
        rd(va);
        cmp(pa_v, tl_pa(pel, va), "single mode");
        // register mirror via a privileged translated page
        va = {3'h6, va[28:11], ~va[10], 10'h000};
        wr(VATU_OFS_PEH, {va[31:10], 2'h0, peh[7:0]});
        ld(32'h1f00_0100);
        dacc(va | 32'h0000_0008, 1'b0, 32'h0000_0000, 1'b1);
        cmpb(isreg_v, 1'b1, "mirror hit");
        cmp(rd_v, translation_table_base, "mirror read");
        // address error captures its page
        @(negedge ref_clk);
        addr_err_va = $urandom();
        addr_err = 1'b1;
        @(negedge ref_clk);
        addr_err = 1'b0;
        rd(VATU_OFS_PEH);
        cmp(rd_v, {addr_err_va[31:10], 2'h0, peh[7:0]}, "error page");
        stop_test();
    end
    // watchdog
    initial begin
        #(20 * 20_000);
        failures++;
        stop_test();
    end
endmodule
bind vatu_top vatu_props vatu_props_inst (.*);
`default_nettype wire
